// [src/hbm_consts.svh]
// Offsets, field positions, reset values and address map of the buffer memory port.
// Assumes inclusion by its bare name from the package and the modules.
`ifndef HBM_CONSTS_SVH
`define HBM_CONSTS_SVH
// Address map seen by the processor
`define HBM_DESC_BASE 16'h0400
`define HBM_DESC_LAST 16'h0fff
`define HBM_PAYLOAD_BASE 16'h1000
`define HBM_DESC_PER_TYPE 32
// Buffer RAM: 64-bit words, 13-bit index
`define HBM_RAM_WORDS 8192
`define HBM_RAM_AW 13
// Register offsets
`define HBM_OFS_HW_CONFIG 16'h0300
`define HBM_OFS_STATUS 16'h0310
`define HBM_OFS_MASK_ANY 16'h0314
`define HBM_OFS_MASK_ALL 16'h0318
`define HBM_OFS_DMA_CFG 16'h0330
`define HBM_OFS_DMA_LEN 16'h0334
`define HBM_OFS_DMA_ADDR 16'h0338
`define HBM_OFS_MEM_PTR 16'h033c
// Field positions and codes
`define HBM_HWCFG_WIDE_BIT 8
`define HBM_DMACFG_WRITE_BIT 0
`define HBM_DMACFG_EN_BIT 1
`define HBM_PTR_BANK_LSB 16
`define HBM_BANK1 2'h1
`define HBM_BANK2 2'h2
// Reset values
`define HBM_RST_HW_CONFIG 32'h0000_0000
`endif

// [src/hbm_pkg.sv]
// Types and shared arithmetic of the buffer memory port.
// Assumes hbm_consts.svh on the include path.
`include "hbm_consts.svh"
package hbm_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} hbm_state_t;

    typedef struct packed {
        hbm_state_t fsm;
        logic ack_meta;
        logic ack_sync;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [31:0] hwcfg;
        logic [1:0] dmacfg;
        logic [15:0] dma_len;
        logic [15:0] dma_addr;
        logic [15:0] dma_beats;
        logic dma_req;
        logic [17:0] ptr_reg;
        logic [1:0][15:0] bptr;
        logic [1:0][63:0] bdat;
        logic [1:0] bok;
        logic [1:0] bvld;
        logic [2:0] st;
        logic [2:0] many;
        logic [2:0] mall;
        logic irq;
        logic [15:0] half;
        logic [15:0] op_a;
        logic [31:0] op_wd;
        logic op_we;
        logic op_pf;
        logic op_bk;
        logic op_bi;
        logic op_dma;
    } hbm_port_state_t;

    typedef struct packed {
        logic last_eng;
        logic cpu_rv;
        logic eng_rv;
        logic [63:0] rdata;
    } hbm_ram_state_t;

    // Address lies in buffer memory space
    function automatic logic in_mem(input logic [15:0] a);
        return a >= `HBM_DESC_BASE;
    endfunction

    // Processor address to RAM word index
    function automatic logic [12:0] mem_index(input logic [15:0] a);
        logic [15:0] d;
        d = a - `HBM_DESC_BASE;
        return d[15:3];
    endfunction

    // Lane of a 64-bit word for sel = address bits 2:1
    function automatic logic [31:0] pick(input logic [63:0] d, input logic [1:0] sel, input logic wide);
        logic [31:0] w;
        w = sel[1] ? d[63:32] : d[31:0];
        return wide ? w : {16'h0000, (sel[0] ? w[31:16] : w[15:0])};
    endfunction

    function automatic logic [7:0] be_of(input logic [1:0] sel, input logic wide);
        return wide ? (sel[1] ? 8'hf0 : 8'h0f) : (8'h03 << {sel, 1'b0});
    endfunction

    function automatic logic [15:0] step_of(input logic wide);
        return wide ? 16'h0004 : 16'h0002;
    endfunction

    // Bus cycles needed for a byte length at the current width
    function automatic logic [15:0] dma_beats(input logic [15:0] len, input logic wide);
        logic [16:0] t;
        t = wide ? (({1'b0, len} + 17'h00003) >> 2) : (({1'b0, len} + 17'h00001) >> 1);
        return t[15:0];
    endfunction
endpackage

// [src/hbm_mem_if.sv]
// Processor-side request path into the buffer RAM.
// Request is held until gnt; read data comes with rvalid one cycle later.
`timescale 1ns/100ps
`default_nettype none
`include "hbm_consts.svh"
interface hbm_mem_if;
    logic req;
    logic we;
    logic [`HBM_RAM_AW-1:0] addr;
    logic [63:0] wdata;
    logic [7:0] be;
    logic gnt;
    logic rvalid;
    logic [63:0] rdata;
    modport cpu (output req, we, addr, wdata, be, input gnt, rvalid, rdata);
    modport ram (input req, we, addr, wdata, be, output gnt, rvalid, rdata);
endinterface
`default_nettype wire

// [src/hbm_ram.sv]
// Buffer RAM with an arbiter between the processor port and the USB engine.
// Both requesters are on the same clock; each holds its request until served.
`timescale 1ns/100ps
`default_nettype none
`include "hbm_consts.svh"
module hbm_ram
    import hbm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Processor side
    hbm_mem_if.ram cpu,
    // USB engine side
    input wire logic eng_req,
    input wire logic eng_we,
    input wire logic [`HBM_RAM_AW-1:0] eng_addr,
    input wire logic [63:0] eng_wdata,
    output logic eng_ack,
    output logic [63:0] eng_rdata
);
    logic [63:0] mem [0:`HBM_RAM_WORDS-1];
    hbm_ram_state_t s;
    hbm_ram_state_t nxt;
    logic eng_live;
    logic cpu_g;
    logic eng_g;
    logic [`HBM_RAM_AW-1:0] a;
    logic [63:0] wd;
    logic [7:0] be;
    logic we;

    // Alternating priority so neither side can starve the other
    always_comb
    begin
        nxt = s;
        eng_live = eng_req & ~s.eng_rv; // Held request is not served twice
        cpu_g = cpu.req & (~eng_live | s.last_eng);
        eng_g = eng_live & ~cpu_g;
        if (cpu_g)
            nxt.last_eng = 1'b0;
        else if (eng_g)
            nxt.last_eng = 1'b1;
        a = cpu_g ? cpu.addr : eng_addr;
        wd = cpu_g ? cpu.wdata : eng_wdata;
        be = cpu_g ? cpu.be : 8'hff;
        we = cpu_g ? cpu.we : (eng_g & eng_we);
        nxt.cpu_rv = cpu_g;
        nxt.eng_rv = eng_g;
        nxt.rdata = mem[a];
        cpu.gnt = cpu_g;
        cpu.rvalid = s.cpu_rv;
        cpu.rdata = s.rdata;
        eng_ack = s.eng_rv;
        eng_rdata = s.rdata;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s <= '0;
        else
            s <= nxt;
    end

    // Byte-lane write, one 64-bit word per cycle
    always_ff @(posedge clk)
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (we && be[i])
                mem[a][i*8 +: 8] <= wd[i*8 +: 8];
        end
    end

    property p_cpu_served;
        @(posedge clk) disable iff (!rst_b) cpu.req |-> ##[0:2] cpu.gnt;
    endproperty
    a_cpu_served: assert property (p_cpu_served) else $error("processor request starved");

    property p_eng_served;
        @(posedge clk) disable iff (!rst_b) (eng_req && !s.eng_rv) |-> ##[1:3] eng_ack;
    endproperty
    a_eng_served: assert property (p_eng_served) else $error("engine request starved");
endmodule
`default_nettype wire

// [src/hbm_port.sv]
// Processor port of the USB host buffer memory: APB slave, banked read prefetch, DMA slave and RAM arbiter.
// Assumes an APB master on REF_CLK, a DMA controller reusing the APB strobes, and a USB engine on REF_CLK.
// Notes on behaviour
// - descriptors at 0400-0FFF, payload 1000-FFFF
// - RAM index is (address - 0400) shifted right three
// - 32 descriptors per transfer type
// - descriptor completion drives interrupt through masks
// - processor accesses can delay an engine request by one grant
// - arbiter shares 64-bit RAM between both
// - hardware config bit 8 picks 16/32 width
// - RAM accesses align to the width: dword at 32 bits, word at 16 bits
// - 16-bit register access uses two halves
// - DMA beat count follows configured width
// - DMA acknowledge replaces select for DMA data
// - DMA request rises once DMA is enabled with a nonzero beat count
// - pointer write stores address, starts prefetch
// - each bank read returns data, advances pointer
// - bank chosen by address 17:16, codes 01/10
// - banks keep separate pointers and interleave
// - prefetch only for pointer in memory space
// - memory writes never auto-increment; DMA writes advance dma_addr by one step per beat
// - read pointer register at offset 033C
// - register accesses never auto-increment
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "hbm_consts.svh"
module hbm_port
    import hbm_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [17:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // DMA handshake pins
    input wire logic DMA_ACKNOWLEDGE_N,
    output logic DMA_REQUEST,
    // USB engine buffer access and completion events
    input wire logic ENG_REQ,
    input wire logic ENG_WE,
    input wire logic [`HBM_RAM_AW-1:0] ENG_ADDR,
    input wire logic [63:0] ENG_WDATA,
    input wire logic [2:0] ENG_DESC_DONE,
    output logic ENG_ACK,
    output logic [63:0] ENG_RDATA,
    // Interrupt
    output logic IRQ
);
    localparam int PF_MAX = 6;

    hbm_mem_if mif ();
    hbm_port_state_t s;
    hbm_port_state_t nxt;
    logic wide;
    logic [15:0] step;
    logic dma_acc;
    logic start;
    logic [1:0] bank;
    logic bi;
    logic [15:0] a;
    logic [15:0] ofs;
    logic is_reg;
    logic is_bank;
    logic hit;
    logic [31:0] rval;
    logic [31:0] wval;
    logic [2:0] clr;
    logic serve;
    logic sbi;
    logic [63:0] sdat;
    logic [15:0] nptr;
    logic [1:0] pb;
    logic [15:0] pa;

    // Shared RAM behind the arbiter
    hbm_ram u_ram (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .cpu(mif.ram),
        .eng_req(ENG_REQ),
        .eng_we(ENG_WE),
        .eng_addr(ENG_ADDR),
        .eng_wdata(ENG_WDATA),
        .eng_ack(ENG_ACK),
        .eng_rdata(ENG_RDATA)
    );

    // Register read mux over dword offsets
    always_comb
    begin
        hit = 1'b1;
        unique case ({a[15:2], 2'b00})
            `HBM_OFS_HW_CONFIG: rval = s.hwcfg;
            `HBM_OFS_STATUS: rval = {29'h0, s.st};
            `HBM_OFS_MASK_ANY: rval = {29'h0, s.many};
            `HBM_OFS_MASK_ALL: rval = {29'h0, s.mall};
            `HBM_OFS_DMA_CFG: rval = {30'h0, s.dmacfg};
            `HBM_OFS_DMA_LEN: rval = {16'h0, s.dma_len};
            `HBM_OFS_DMA_ADDR: rval = {16'h0, s.dma_addr};
            `HBM_OFS_MEM_PTR: rval = {14'h0, s.ptr_reg};
            default:
            begin
                rval = 32'h0;
                hit = 1'b0;
            end
        endcase
    end

    // Whole next state of the port
    always_comb
    begin
        nxt = s;
        serve = 1'b0;
        sbi = 1'b0;
        sdat = 64'h0;
        clr = 3'h0;
        nptr = 16'h0;
        pb = 2'h0;
        pa = 16'h0;
        nxt.pready = 1'b0;
        nxt.pslverr = 1'b0;
        // Acknowledge pin goes through two flops before use
        nxt.ack_meta = ~DMA_ACKNOWLEDGE_N;
        nxt.ack_sync = s.ack_meta;
        wide = s.hwcfg[`HBM_HWCFG_WIDE_BIT];
        step = step_of(wide);
        dma_acc = s.dmacfg[`HBM_DMACFG_EN_BIT] & s.ack_sync;
        start = (PSEL | dma_acc) & PENABLE & ~s.pready & (s.fsm == ST_IDLE);
        bank = PADDR[17:16];
        bi = (bank == `HBM_BANK2);
        a = dma_acc ? s.dma_addr : PADDR[15:0];
        ofs = {a[15:2], 2'b00};
        is_reg = ~dma_acc & (bank == 2'h0) & (a < `HBM_DESC_BASE);
        is_bank = ~dma_acc & ((bank == `HBM_BANK1) | (bank == `HBM_BANK2)) & ~PWRITE & s.bok[bi];
        // In 16-bit width the high half completes the register value
        wval = wide ? PWDATA : {PWDATA[15:0], s.half};
        mif.req = 1'b0;
        mif.we = s.op_we;
        mif.addr = mem_index(s.op_a);
        mif.wdata = wide ? {2{s.op_wd}} : {4{s.op_wd[15:0]}};
        mif.be = s.op_we ? be_of(s.op_a[2:1], wide) : 8'h00;
        unique case (s.fsm)
            ST_IDLE:
            begin
                if (start && is_reg)
                begin
                    // Register access at the given offset, no increment
                    nxt.pready = 1'b1;
                    nxt.pslverr = ~hit;
                    if (!PWRITE)
                    begin
                        nxt.prdata = wide ? rval : {16'h0, (a[1] ? s.half : rval[15:0])};
                        if (!wide && !a[1])
                            nxt.half = rval[31:16];
                    end
                    else if (!wide && !a[1])
                        nxt.half = PWDATA[15:0];
                    else if (hit)
                    begin
                        unique case (ofs)
                            `HBM_OFS_HW_CONFIG: nxt.hwcfg = wval;
                            `HBM_OFS_STATUS: clr = wval[2:0];
                            `HBM_OFS_MASK_ANY: nxt.many = wval[2:0];
                            `HBM_OFS_MASK_ALL: nxt.mall = wval[2:0];
                            `HBM_OFS_DMA_CFG:
                            begin
                                nxt.dmacfg = wval[1:0];
                                if (wval[`HBM_DMACFG_EN_BIT] && !s.dmacfg[`HBM_DMACFG_EN_BIT])
                                    nxt.dma_beats = dma_beats(s.dma_len, wide);
                            end
                            `HBM_OFS_DMA_LEN:
                            begin
                                nxt.dma_len = wval[15:0];
                                nxt.dma_beats = dma_beats(wval[15:0], wide);
                            end
                            `HBM_OFS_DMA_ADDR: nxt.dma_addr = {wval[15:2], (wide ? 1'b0 : wval[1]), 1'b0};
                            `HBM_OFS_MEM_PTR:
                            begin
                                // Store the start address and kick the bank's first fetch
                                nxt.ptr_reg = wval[17:0];
                                pb = wval[`HBM_PTR_BANK_LSB +: 2];
                                pa = {wval[15:2], (wide ? 1'b0 : wval[1]), 1'b0};
                                if (pb == `HBM_BANK1 || pb == `HBM_BANK2)
                                begin
                                    nxt.bptr[pb == `HBM_BANK2] = pa;
                                    nxt.bok[pb == `HBM_BANK2] = in_mem(pa);
                                    nxt.bvld[pb == `HBM_BANK2] = 1'b0;
                                    if (in_mem(pa))
                                    begin
                                        nxt.fsm = ST_REQ;
                                        nxt.op_bk = 1'b1;
                                        nxt.op_pf = 1'b1;
                                        nxt.op_bi = (pb == `HBM_BANK2);
                                        nxt.op_a = pa;
                                        nxt.op_we = 1'b0;
                                        nxt.op_dma = 1'b0;
                                    end
                                end
                            end
                            default: nxt.hwcfg = s.hwcfg;
                        endcase
                    end
                end
                else if (start && is_bank)
                begin
                    // Bank read ignores address bits 15:0
                    if (s.bvld[bi])
                    begin
                        serve = 1'b1;
                        sbi = bi;
                        sdat = s.bdat[bi];
                    end
                    else
                    begin
                        nxt.fsm = ST_REQ;
                        nxt.op_bk = 1'b1;
                        nxt.op_pf = 1'b0;
                        nxt.op_bi = bi;
                        nxt.op_a = s.bptr[bi];
                        nxt.op_we = 1'b0;
                        nxt.op_dma = 1'b0;
                    end
                end
                else if (start && in_mem(a))
                begin
                    // Direct memory or DMA access; writes use the address as given
                    nxt.fsm = ST_REQ;
                    nxt.op_bk = 1'b0;
                    nxt.op_pf = 1'b0;
                    nxt.op_a = a;
                    nxt.op_we = PWRITE;
                    nxt.op_wd = PWDATA;
                    nxt.op_dma = dma_acc;
                end
                else if (start)
                begin
                    nxt.pready = 1'b1;
                    nxt.pslverr = 1'b1;
                end
            end
            ST_REQ:
            begin
                // Hold the request until the arbiter grants it
                mif.req = 1'b1;
                if (mif.gnt)
                    nxt.fsm = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (mif.rvalid)
                begin
                    nxt.fsm = ST_IDLE;
                    if (s.op_bk)
                    begin
                        nxt.bdat[s.op_bi] = mif.rdata;
                        nxt.bvld[s.op_bi] = s.op_pf;
                        serve = ~s.op_pf;
                        sbi = s.op_bi;
                        sdat = mif.rdata;
                    end
                    else
                    begin
                        nxt.pready = 1'b1;
                        if (!s.op_we)
                            nxt.prdata = pick(mif.rdata, s.op_a[2:1], wide);
                        if (s.op_dma)
                        begin
                            // DMA address advances per beat; the count ends the request
                            nxt.dma_addr = s.dma_addr + step;
                            if (s.dma_beats != 16'h0)
                                nxt.dma_beats = s.dma_beats - 16'h0001;
                        end
                    end
                end
            end
        endcase
        // Answer a bank read and move that bank on; refetch lazily on word change
        if (serve)
        begin
            nptr = s.bptr[sbi] + step;
            nxt.pready = 1'b1;
            nxt.prdata = pick(sdat, s.bptr[sbi][2:1], wide);
            nxt.bptr[sbi] = nptr;
            nxt.bvld[sbi] = (nptr[15:3] == s.bptr[sbi][15:3]);
        end
        // Completion sets win over a same-cycle write-one clear
        nxt.st = (s.st & ~clr) | ENG_DESC_DONE;
        nxt.irq = ((s.st & s.many) != 3'h0) || ((s.mall != 3'h0) && ((s.st & s.mall) == s.mall));
        nxt.dma_req = s.dmacfg[`HBM_DMACFG_EN_BIT] & (s.dma_beats != 16'h0);
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            s <= '0;
            s.hwcfg <= `HBM_RST_HW_CONFIG;
        end
        else
            s <= nxt;
    end

    // Outputs straight from the state register
    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign DMA_REQUEST = s.dma_req;
    assign IRQ = s.irq;

    property p_reg_keeps_banks;
        @(posedge REF_CLK) disable iff (!RST_B) (start && is_reg && !PWRITE) |=> (s.bptr == $past(s.bptr));
    endproperty
    a_reg_keeps_banks: assert property (p_reg_keeps_banks) else $error("register read moved a bank pointer");

    property p_bank_step;
        @(posedge REF_CLK) disable iff (!RST_B)
            (start && is_bank && !bi && s.bvld[0]) |=> (PREADY && s.bptr[0] == $past(s.bptr[0]) + $past(step));
    endproperty
    a_bank_step: assert property (p_bank_step) else $error("bank read did not advance by one unit");

    property p_ptr_prefetch;
        @(posedge REF_CLK) disable iff (!RST_B)
            (s.fsm == ST_IDLE && nxt.fsm == ST_REQ && nxt.op_pf)
            |=> ##[0:PF_MAX] (s.fsm == ST_IDLE && s.bvld[s.op_bi]);
    endproperty
    a_ptr_prefetch: assert property (p_ptr_prefetch) else $error("pointer write did not prefetch");

    property p_dma_request;
        @(posedge REF_CLK) disable iff (!RST_B)
            (s.dmacfg[`HBM_DMACFG_EN_BIT] && s.dma_beats != 16'h0) |=> DMA_REQUEST;
    endproperty
    a_dma_request: assert property (p_dma_request) else $error("DMA request missing while enabled");

    property p_irq_any;
        @(posedge REF_CLK) disable iff (!RST_B) ((s.st & s.many) != 3'h0) |=> IRQ;
    endproperty
    a_irq_any: assert property (p_irq_any) else $error("masked completion gave no interrupt");

    property p_narrow_read;
        @(posedge REF_CLK) disable iff (!RST_B)
            (PREADY && !PWRITE && !PSLVERR && !s.hwcfg[`HBM_HWCFG_WIDE_BIT]) |-> (PRDATA[31:16] == 16'h0);
    endproperty
    a_narrow_read: assert property (p_narrow_read) else $error("16-bit read drove upper half");
endmodule
`default_nettype wire

// [verif/hbm_host_model.sv]
// Processor-side APB master and a reading USB engine for the buffer memory port.
// Assumes the bench seeds the random source and calls xfer only after reset.
`timescale 1ns/100ps
`default_nettype none
module hbm_host_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [17:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // DMA pin and engine side
    output logic dma_ack_n,
    output logic eng_req,
    output logic [12:0] eng_addr,
    input wire logic eng_ack
);
    // Acknowledge starts inactive; dma_ack hands the strobes over to DMA cycles
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h00000;
        pwdata = 32'h0;
        dma_ack_n = 1'b1;
    end

    // Engine reads at random to compete for the RAM; it never writes, so stored data stays known
    always @(posedge clk or negedge rst_b)
        if (!rst_b)
            eng_req <= 1'b0;
        else if (eng_req)
            eng_req <= !eng_ack;
        else if ($urandom_range(3) == 0)
        begin
            eng_req <= 1'b1;
            eng_addr <= 13'($urandom);
        end

    // One aligned access, a fresh address every time, held until pready
    task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        // Released lines must not keep showing the last value
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask

    // Moves the acknowledge pin and waits out the port's two-flop synchroniser
    task automatic dma_ack(input logic on);
        @(posedge clk);
        dma_ack_n <= !on;
        repeat (2) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [verif/hbm_port_test.sv]
// Self-checking bench for the buffer memory port: width, memory map, banked prefetch, DMA request.
// Assumes the design files in src and the host model in verif.
`timescale 1ns/100ps
`default_nettype none
module hbm_port_test;
    logic REF_CLK = 1'b0;
    logic RST_B = 1'b0;
    logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, DMA_ACKNOWLEDGE_N, DMA_REQUEST, ENG_REQ, ENG_ACK;
    logic [17:0] PADDR;
    logic [31:0] PWDATA, PRDATA, q;
    logic [12:0] ENG_ADDR;
    logic e, IRQ;
    logic [2:0] done = 3'h0;
    logic [31:0] mem [logic [15:0]];
    logic [15:0] edge_a [4] = '{16'h0400, 16'h0ffc, 16'h1000, 16'hfffc};
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #50 REF_CLK = ~REF_CLK;

    // Engine writes are left idle; completion events come from done
    hbm_port hbm_port_inst (.REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .DMA_ACKNOWLEDGE_N(DMA_ACKNOWLEDGE_N), .DMA_REQUEST(DMA_REQUEST),
        .ENG_REQ(ENG_REQ), .ENG_WE(1'b0), .ENG_ADDR(ENG_ADDR), .ENG_WDATA(64'h0),
        .ENG_DESC_DONE(done), .ENG_ACK(ENG_ACK), .ENG_RDATA(), .IRQ(IRQ));
    hbm_host_model hbm_host_model_inst (.clk(REF_CLK), .rst_b(RST_B), .psel(PSEL), .penable(PENABLE),
        .pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY),
        .pslverr(PSLVERR), .dma_ack_n(DMA_ACKNOWLEDGE_N), .eng_req(ENG_REQ), .eng_addr(ENG_ADDR),
        .eng_ack(ENG_ACK));

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask

    // Stored word at a processor byte address
    function automatic logic [31:0] exp_rd(input logic [15:0] a);
        return mem[a];
    endfunction

    task automatic wr(input logic [17:0] a, input logic [31:0] d);
        hbm_host_model_inst.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [17:0] a, input logic [31:0] x, input string n);
        hbm_host_model_inst.xfer(1'b0, a, 32'h0, q, e);
        check(n, q, x);
    endtask

    // Bank read with a random aligned low address that the bank must ignore
    task automatic bank_rd(input logic [1:0] b, input logic [15:0] a);
        rd({b, 16'h0400 | 16'($urandom & 32'hfffc)}, exp_rd(a), "bank data");
    endtask

    task complete_run;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Cuts a hang short
    always @(posedge REF_CLK)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            complete_run;
        end
    end

    initial
    begin
        void'($urandom(32'hcd128636));
        repeat (2) @(posedge REF_CLK);
        RST_B <= 1'b1;
        // Out of reset the port is 16 bits wide; its halves switch it to 32-bit width
        rd(18'h00300, 32'h0, "narrow width");
        wr(18'h00300, 32'h0100);
        wr(18'h00302, 32'h0000);
        rd(18'h00300, 32'h100, "width");
        // Last of the 32 asynchronous-zone descriptors: eight dwords, reserved bits zero
        for (int i = 0; i < 8; i++)
        begin
            mem[16'h0fe0 + 16'(4 * i)] = 32'h0;
            wr(18'h00fe0 + 18'(4 * i), 32'h0);
        end
        rd(18'h00fe0, exp_rd(16'h0fe0), "descriptor");
        // Each write carries its own address; edges of the map included
        for (int i = 0; i < 20; i++)
        begin
            logic [15:0] a;
            a = (i < 4) ? edge_a[i] : 16'h4000 + 16'(4 * (i - 4));
            mem[a] = $urandom;
            wr({2'b00, a}, mem[a]);
        end
        for (int i = 0; i < 4; i++)
            rd({2'b00, edge_a[i]}, exp_rd(edge_a[i]), "direct");
        rd(18'h04004, exp_rd(16'h4004), "direct");
        // Two banks loaded, then interleaved
        wr(18'h0033c, {14'h0, 2'b01, 16'h4000});
        wr(18'h0033c, {14'h0, 2'b10, 16'h4010});
        for (int i = 0; i < 3; i++)
            bank_rd(2'b01, 16'h4000 + 16'(4 * i));
        for (int i = 0; i < 2; i++)
            bank_rd(2'b10, 16'h4010 + 16'(4 * i));
        rd(18'h00300, 32'h100, "register");
        bank_rd(2'b01, 16'h400c);
        bank_rd(2'b10, 16'h4018);
        // Pointer below memory space: bank reads fall back to the given address
        wr(18'h0033c, {14'h0, 2'b01, 16'h0100});
        rd({2'b01, 16'h4008}, exp_rd(16'h4008), "no prefetch");
        // Unmapped register is refused
        hbm_host_model_inst.xfer(1'b0, 18'h00000, 32'h0, q, e);
        check("refused", {31'h0, e}, 32'h1);
        // Asynchronous completion raises the interrupt through the any-mask; write-one clears it
        wr(18'h00314, 32'h4);
        done <= 3'h4;
        @(posedge REF_CLK);
        done <= 3'h0;
        repeat (2) @(posedge REF_CLK);
        check("interrupt", {31'h0, IRQ}, 32'h1);
        wr(18'h00310, 32'h4);
        @(posedge REF_CLK);
        check("interrupt clear", {31'h0, IRQ}, 32'h0);
        // DMA request follows the enable
        wr(18'h00338, 32'h4000);
        wr(18'h00334, 32'h8);
        wr(18'h00330, 32'h2);
        repeat (2) @(posedge REF_CLK);
        check("dma request", {31'h0, DMA_REQUEST}, 32'h1);
        // Acknowledge replaces select and address; 8 bytes at 32 bits are two beats
        hbm_host_model_inst.dma_ack(1'b1);
        rd(18'h00000, exp_rd(16'h4000), "dma data");
        rd(18'h00000, exp_rd(16'h4004), "dma data");
        hbm_host_model_inst.dma_ack(1'b0);
        check("dma request end", {31'h0, DMA_REQUEST}, 32'h0);
        complete_run;
    end
endmodule
`default_nettype wire
